// [design/adc_mux_pkg.sv]
// types shared by the converter control block
// assumes nothing beyond a SystemVerilog compiler
package adc_mux_pkg;

  typedef enum logic [1:0] {
    REF_EXT_PIN = 2'b00,
    REF_ANALOG_SUPPLY = 2'b01,
    REF_INT_1V1 = 2'b10,
    REF_INT_2V56 = 2'b11
  } ref_t;

  typedef enum logic {
    CONV_IDLE = 1'b0,
    CONV_BUSY = 1'b1
  } conv_state_t;

  typedef struct packed {
    logic write;
    logic read;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic start;
    logic done;
    logic [9:0] code;
  } conv_evt_t;

endpackage : adc_mux_pkg

// [design/adc_mux_regs.svh]
// register offsets, field positions and reset values of the converter
// control block; included by the control block design file only, holds definitions only
`ifndef ADC_MUX_REGS_SVH
`define ADC_MUX_REGS_SVH

`define OFF_RESULT_LOW 8'h78
`define OFF_RESULT_HIGH 8'h79
`define OFF_CTRL_B 8'h7B
`define OFF_MUX_SEL 8'h7C
`define OFF_IRQ_STATUS 8'h7D
`define OFF_IRQ_MASK 8'h7E

`define RST_CTRL_B 8'h00
`define RST_MUX_SEL 8'h00
`define RST_IRQ 2'h0

`define CTRLB_WMASK 8'h4F
`define CTRLB_CMPEN_BIT 6
`define CTRLB_CHHI_BIT 3
`define MUXSEL_LADJ_BIT 5

`define CHAN_BANDGAP 6'h1E
`define CHAN_GROUND 6'h1F

`define IRQ_DONE_BIT 0
`define IRQ_NEG_BIT 1

`endif

// [design/adc_result_mux_ctrl.sv]
// control and result formatting of a 10-bit successive-approximation
// converter: selection registers, deferred selection, result bytes
// assumes the sequencer on the same clock gives start and done pulses
//
// Functional notes
// - after done and flag set, the 10-bit result appears in both bytes
// - single-ended code is unsigned, differential code scaled by 512
// - single-ended 0x000 means ground, 0x3FF means reference less one step
// - differential codes are two's complement from 0x200 to 0x1FF
// - top result bit is the sign and lives in the high byte
// - selection register at 0x7C, resets zero, all bits read/write
// - reference field selects pin, supply, internal 1.1V or 2.56V
// - reference change in a conversion waits for its completion
// - low channel bits written in a conversion wait for completion
// - alignment bit one left adjusts, zero right adjusts
// - alignment change reformats the read value at once
// - control register B at 0x7B, resets zero, spare bits read zero
// - top channel bit joins low five, change deferred likewise
// - code 011110 routes the bandgap, 011111 routes ground
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

`include "adc_mux_regs.svh"

module adc_result_mux_ctrl
  import adc_mux_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // register port
  input wire reg_req_t regReq,
  output logic [7:0] regRdata,
  // sequencer
  input wire conv_evt_t convEvt,
  output logic convBusy,
  // analog front end
  output var ref_t activeRef,
  output logic [5:0] activeChan,
  output logic diffMode,
  output logic routeBandgap,
  output logic routeGround,
  output logic compMuxEnable,
  output logic [2:0] triggerSource,
  // interrupt
  output logic irq
);

  logic [7:0] muxSel;
  logic [7:0] ctrlB;
  logic [9:0] resultCode;
  logic [1:0] irqStatus;
  logic [1:0] irqMask;
  logic [1:0] next_irqStatus;
  logic [1:0] irqEvents;
  logic [7:0] next_rdata;
  logic [7:0] lowByte;
  logic [7:0] highByte;
  logic [1:0] refActiveBits;
  conv_state_t convState;

  // a channel code is a differential pair when bits 4:3 are not zero,
  // except for the two fixed single-ended sources at the top
  function automatic logic isDiffChan(input logic [5:0] chan);
    isDiffChan = (chan[4:3] != 2'b00) && (chan[4:0] < 5'(`CHAN_BANDGAP));
  endfunction : isDiffChan

  function automatic logic hit(input reg_req_t req, input logic [7:0] off);
    hit = req.addr == off;
  endfunction : hit

  // conversion tracking
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      convState <= CONV_IDLE;
    end else begin
      case (convState)
        CONV_IDLE: begin
          if (convEvt.start && !convEvt.done) begin
            convState <= CONV_BUSY;
          end
        end
        CONV_BUSY: begin
          if (convEvt.done) begin
            convState <= CONV_IDLE;
          end
        end
        default: begin
          convState <= CONV_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      convBusy <= 1'b0;
    end else begin
      convBusy <= (convState == CONV_BUSY) ? !convEvt.done : (convEvt.start && !convEvt.done);
    end
  end

  // selection register, every bit writable
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      muxSel <= `RST_MUX_SEL;
    end else if (regReq.write && hit(regReq, `OFF_MUX_SEL)) begin
      muxSel <= regReq.wdata;
    end
  end

  // control register B; spare bits never store
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrlB <= `RST_CTRL_B;
    end else if (regReq.write && hit(regReq, `OFF_CTRL_B)) begin
      ctrlB <= regReq.wdata & `CTRLB_WMASK;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      compMuxEnable <= 1'b0;
      triggerSource <= 3'h0;
    end else begin
      compMuxEnable <= ctrlB[`CTRLB_CMPEN_BIT];
      triggerSource <= ctrlB[2:0];
    end
  end

  // deferred selections: the written value reaches the analog side
  // only outside a conversion, so the sample in flight stays coherent
  deferred_sel #(
    .W(2)
  ) u_refSel (
    .clk(clk),
    .nrst(nrst),
    .hold(convBusy),
    .written(muxSel[7:6]),
    .active(refActiveBits)
  );

  deferred_sel #(
    .W(6)
  ) u_chanSel (
    .clk(clk),
    .nrst(nrst),
    .hold(convBusy),
    .written({ctrlB[`CTRLB_CHHI_BIT], muxSel[4:0]}),
    .active(activeChan)
  );

  assign activeRef = ref_t'(refActiveBits);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      diffMode <= 1'b0;
      routeBandgap <= 1'b0;
      routeGround <= 1'b0;
    end else begin
      diffMode <= isDiffChan(activeChan);
      routeBandgap <= activeChan == `CHAN_BANDGAP;
      routeGround <= activeChan == `CHAN_GROUND;
    end
  end

  // result capture; the code is kept raw: unsigned for single-ended,
  // two's complement for differential, as the converter delivers it
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      resultCode <= 10'h000;
    end else if (convEvt.done) begin
      resultCode <= convEvt.code;
    end
  end

  result_align u_align (
    .code(resultCode),
    .leftAdjust(muxSel[`MUXSEL_LADJ_BIT]),
    .lowByte(lowByte),
    .highByte(highByte)
  );

  // interrupt events: completion, and a negative differential result
  always_comb begin
    irqEvents = 2'h0;
    irqEvents[`IRQ_DONE_BIT] = convEvt.done;
    irqEvents[`IRQ_NEG_BIT] = convEvt.done && diffMode && convEvt.code[9];
  end

  // a read clears the status, but an event in the same cycle survives
  always_comb begin
    next_irqStatus = irqStatus;
    if (regReq.read && hit(regReq, `OFF_IRQ_STATUS)) begin
      next_irqStatus = 2'h0;
    end
    next_irqStatus = next_irqStatus | irqEvents;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irqStatus <= `RST_IRQ;
    end else begin
      irqStatus <= next_irqStatus;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irqMask <= `RST_IRQ;
    end else if (regReq.write && hit(regReq, `OFF_IRQ_MASK)) begin
      irqMask <= regReq.wdata[1:0];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(next_irqStatus & irqMask);
    end
  end

  // read data: valid only in the cycle after the strobe, zero elsewhere
  always_comb begin
    next_rdata = 8'h00;
    if (!regReq.read) begin
      next_rdata = 8'h00;
    end else if (hit(regReq, `OFF_RESULT_LOW)) begin
      next_rdata = lowByte;
    end else if (hit(regReq, `OFF_RESULT_HIGH)) begin
      next_rdata = highByte;
    end else if (hit(regReq, `OFF_CTRL_B)) begin
      next_rdata = ctrlB & `CTRLB_WMASK;
    end else if (hit(regReq, `OFF_MUX_SEL)) begin
      next_rdata = muxSel;
    end else if (hit(regReq, `OFF_IRQ_STATUS)) begin
      next_rdata = {6'h00, irqStatus};
    end else if (hit(regReq, `OFF_IRQ_MASK)) begin
      next_rdata = {6'h00, irqMask};
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      regRdata <= 8'h00;
    end else begin
      regRdata <= next_rdata;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  refDeferred_a: assert property (
    convBusy && regReq.write && hit(regReq, `OFF_MUX_SEL) |=> $stable(activeRef))
    else $error("reference moved during a conversion");

  chanDeferred_a: assert property (
    convBusy ##1 convBusy |-> $stable(activeChan))
    else $error("channel moved during a conversion");

  chanApplied_a: assert property (
    !convBusy ##1 !convBusy |-> activeChan == $past({ctrlB[3], muxSel[4:0]}))
    else $error("idle channel not applied");

  resultCapture_a: assert property (
    convEvt.done ##1 regReq.read && hit(regReq, `OFF_RESULT_LOW)
      && !muxSel[5] |=> regRdata == $past(convEvt.code[7:0], 2))
    else $error("low result byte wrong after completion");

  leftHigh_a: assert property (
    regReq.read && hit(regReq, `OFF_RESULT_HIGH) && muxSel[5] |=>
      regRdata == $past(resultCode[9:2]))
    else $error("left adjusted high byte wrong");

  rightHigh_a: assert property (
    regReq.read && hit(regReq, `OFF_RESULT_HIGH) && !muxSel[5] |=>
      regRdata == {6'h00, $past(resultCode[9:8])})
    else $error("right adjusted high byte wrong");

  alignAtOnce_a: assert property (
    regReq.write && hit(regReq, `OFF_MUX_SEL) && regReq.wdata[5]
      ##1 regReq.read && hit(regReq, `OFF_RESULT_LOW) |=>
      regRdata[5:0] == 6'h00)
    else $error("alignment change not seen at once");

  spareZero_a: assert property (
    regReq.read && hit(regReq, `OFF_CTRL_B) |=> (regRdata & 8'hB0) == 8'h00)
    else $error("spare control bits read nonzero");

  muxReadBack_a: assert property (
    regReq.write && hit(regReq, `OFF_MUX_SEL) ##1
      regReq.read && hit(regReq, `OFF_MUX_SEL) |=> regRdata == $past(regReq.wdata, 2))
    else $error("selection register read back wrong");

  negSign_a: assert property (
    convEvt.done && diffMode && convEvt.code[9] |=> irqStatus[1])
    else $error("negative differential result not flagged");

  groundRoute_a: assert property (
    activeChan == 6'h1F ##1 activeChan == 6'h1F |-> routeGround && !routeBandgap)
    else $error("ground source not routed");

  refApplied_a: assert property (
    !convBusy |=> refActiveBits == $past(muxSel[7:6]))
    else $error("idle reference not applied");

  rightLow_a: assert property (
    regReq.read && hit(regReq, `OFF_RESULT_LOW) && !muxSel[5] |=>
      regRdata == $past(resultCode[7:0]))
    else $error("right adjusted low byte wrong");

  leftLow_a: assert property (
    regReq.read && hit(regReq, `OFF_RESULT_LOW) && muxSel[5] |=>
      regRdata == {$past(resultCode[1:0]), 6'h00})
    else $error("left adjusted low byte wrong");

  bandgapRoute_a: assert property (
    activeChan == 6'h1E ##1 activeChan == 6'h1E |-> routeBandgap && !routeGround)
    else $error("bandgap source not routed");

  spareDrop_a: assert property (
    regReq.write && hit(regReq, `OFF_CTRL_B) |=> ctrlB == ($past(regReq.wdata) & 8'h4F))
    else $error("spare control bits stored");

  compMuxFollow_a: assert property (
    regReq.write && hit(regReq, `OFF_CTRL_B) |=> ##1
      compMuxEnable == $past(regReq.wdata[6], 2))
    else $error("comparator mux enable not applied");

  resultHold_a: assert property (
    !convEvt.done |=> $stable(resultCode))
    else $error("result changed without completion");

endmodule : adc_result_mux_ctrl

`default_nettype wire

// [design/deferred_sel.sv]
// holds a selection that software may rewrite at any time and lets the
// analog side see it only while no conversion is running
// assumes hold is a registered level on the same clock
`timescale 1ns/1ps
`default_nettype none

module deferred_sel #(
  parameter int W = 2
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // selection
  input wire logic hold,
  input wire logic [W-1:0] written,
  output logic [W-1:0] active
);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      active <= '0;
    end else if (!hold) begin
      active <= written;
    end
  end

  holdStable_a: assert property (@(posedge clk) disable iff (!nrst)
    hold |=> $stable(active)) else $error("active selection moved in a conversion");

endmodule : deferred_sel

`default_nettype wire

// [design/result_align.sv]
// lays the stored 10-bit result across the low and high byte registers
// combinational; the caller registers the read data
`timescale 1ns/1ps
`default_nettype none

module result_align (
  // result in
  input wire logic [9:0] code,
  input wire logic leftAdjust,
  // byte view out
  output logic [7:0] lowByte,
  output logic [7:0] highByte
);

  // alignment is applied at read time so a flip shows at once
  always_comb begin
    if (leftAdjust) begin
      highByte = code[9:2];
      lowByte = {code[1:0], 6'h00};
    end else begin
      highByte = {6'h00, code[9:8]};
      lowByte = code[7:0];
    end
  end

endmodule : result_align

`default_nettype wire

// [verification/adc_result_and_mux_control_test.sv]
// self-checking bench of the converter control block
// assumes the sequencer model answers every start with one done
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin testsRun++; if ((a) !== (e)) begin badCount++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, (a), (e)); end end

module adc_result_and_mux_control_test
  import adc_mux_pkg::*;
;
  localparam int DLY = 8;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  reg_req_t regReq = '0;
  logic go = 1'b0;
  logic [9:0] goCode = '0;
  conv_evt_t convEvt;
  logic [7:0] regRdata;
  logic convBusy;
  ref_t activeRef;
  logic [5:0] activeChan;
  logic diffMode;
  logic routeBandgap;
  logic routeGround;
  logic compMuxEnable;
  logic [2:0] triggerSource;
  logic irq;
  logic [7:0] d;
  int badCount = 0;
  int testsRun = 0;

  adc_result_mux_ctrl adc_result_mux_ctrl_inst (
    .clk(clk), .nrst(nrst), .regReq(regReq), .regRdata(regRdata),
    .convEvt(convEvt), .convBusy(convBusy), .activeRef(activeRef),
    .activeChan(activeChan), .diffMode(diffMode), .routeBandgap(routeBandgap),
    .routeGround(routeGround), .compMuxEnable(compMuxEnable),
    .triggerSource(triggerSource), .irq(irq)
  );

  conv_seq_model #(.DLY(DLY)) conv_seq_model_inst (
    .clk(clk), .nrst(nrst), .go(go), .goCode(goCode), .evt(convEvt)
  );

  initial begin
    forever #2.5 clk = ~clk;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    regReq <= reg_req_t'{1'b1, 1'b0, a, v};
    @(posedge clk);
    regReq <= '0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    regReq <= reg_req_t'{1'b0, 1'b1, a, 8'h00};
    @(posedge clk);
    regReq <= '0;
    #1 d = regRdata;
  endtask : rd

  task automatic conv_start(input logic [9:0] c);
    @(posedge clk);
    go <= 1'b1;
    goCode <= c;
    @(posedge clk);
    go <= 1'b0;
  endtask : conv_start

  task automatic conv_wait();
    repeat (DLY + 4) @(posedge clk);
    #1;
  endtask : conv_wait

  task automatic t_regs();
    `CHK(irq, 1'b0)
    rd(8'h7C); `CHK(d, 8'h00)
    rd(8'h7B); `CHK(d, 8'h00)
    wr(8'h7C, 8'hA5);
    rd(8'h7C); `CHK(d, 8'hA5)
    wr(8'h7B, 8'hFF);
    rd(8'h7B); `CHK(d, 8'h4F)
    `CHK(compMuxEnable, 1'b1)
    `CHK(triggerSource, 3'h7)
    `CHK(activeChan, 6'h25)
    wr(8'h7B, 8'h00);
    rd(8'h10); `CHK(d, 8'h00)
  endtask : t_regs

  // no external reference is modelled, so every choice, the external pin included, is safe
  task automatic t_ref();
    for (int r = 0; r < 4; r++) begin
      wr({r[1:0], 6'h00}, 8'h00);
      wr(8'h7C, {r[1:0], 6'h00});
      repeat (3) @(posedge clk);
      `CHK(activeRef, ref_t'(r[1:0]))
    end
  endtask : t_ref

  task automatic t_defer();
    wr(8'h7C, 8'h40);
    conv_start(10'h155);
    wr(8'h7C, 8'hC7);
    wr(8'h7B, 8'h08);
    repeat (2) @(posedge clk);
    `CHK(convBusy, 1'b1)
    `CHK(activeRef, REF_ANALOG_SUPPLY)
    `CHK(activeChan, 6'h00)
    conv_wait();
    `CHK(activeRef, REF_INT_2V56)
    `CHK(activeChan, 6'h27)
    wr(8'h7B, 8'h00);
    rd(8'h78); `CHK(d, 8'h55)
    rd(8'h79); `CHK(d, 8'h01)
    rd(8'h7D); `CHK(d, 8'h01)
    `CHK(irq, 1'b0)
  endtask : t_defer

  task automatic t_diff();
    wr(8'h7E, 8'h03);
    wr(8'h7C, 8'hED);
    conv_start(10'h270);
    conv_wait();
    `CHK(diffMode, 1'b1)
    `CHK(irq, 1'b1)
    rd(8'h79); `CHK(d, 8'h9C)
    rd(8'h78); `CHK(d, 8'h00)
    rd(8'h7D); `CHK(d, 8'h03)
    `CHK(irq, 1'b0)
    conv_start(10'h1FF);
    wr(8'h7C, 8'hCD);
    rd(8'h78); `CHK(d, 8'h70)
    rd(8'h79); `CHK(d, 8'h02)
    conv_wait();
    rd(8'h79); `CHK(d, 8'h01)
    rd(8'h78); `CHK(d, 8'hFF)
    rd(8'h7D); `CHK(d, 8'h01)
  endtask : t_diff

  task automatic t_route();
    wr(8'h7E, 8'h00);
    wr(8'h7C, 8'h1E);
    repeat (3) @(posedge clk);
    `CHK(routeBandgap, 1'b1)
    `CHK(routeGround, 1'b0)
    wr(8'h7C, 8'h1F);
    repeat (3) @(posedge clk);
    `CHK(routeGround, 1'b1)
    `CHK(diffMode, 1'b0)
    conv_start(10'h3FF);
    conv_wait();
    `CHK(irq, 1'b0)
    rd(8'h78); `CHK(d, 8'hFF)
    rd(8'h79); `CHK(d, 8'h03)
    conv_start(10'h000);
    conv_wait();
    rd(8'h78); `CHK(d, 8'h00)
  endtask : t_route

  task automatic stopTest();
    $display("checks %0d mismatches %0d", testsRun, badCount);
    if (badCount == 0 && testsRun > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stopTest

  // whole run is well under two thousand cycles
  initial begin
    #50000;
    badCount++;
    stopTest();
  end

  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    t_regs();
    t_ref();
    t_defer();
    t_diff();
    t_route();
    stopTest();
  end
endmodule : adc_result_and_mux_control_test

`default_nettype wire

// [verification/conv_seq_model.sv]
// behavioural sequencer on the far side of the conversion event port
// assumes the bench pulses go for one cycle only while no conversion runs
`timescale 1ns/1ps
`default_nettype none

module conv_seq_model
  import adc_mux_pkg::*;
#(
  parameter int DLY = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // bench request
  input wire logic go,
  input wire logic [9:0] goCode,
  // events to the block
  output conv_evt_t evt
);
  int cnt;
  logic [9:0] held;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt <= 0;
      held <= '0;
      evt <= '0;
    end else begin
      evt.start <= go && cnt == 0;
      evt.done <= cnt == 1;
      // code is only meaningful beside done, so show garbage otherwise
      evt.code <= (cnt == 1) ? held : ~held;
      if (go && cnt == 0) begin
        cnt <= DLY;
        held <= goCode;
      end else if (cnt != 0) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule : conv_seq_model

`default_nettype wire
